/* hw/reset_strap_config_capture.sv */
// strap capture at reset release plus the software device config register
//
// Behaviour
// - byte order strap low means big endian, high means little endian.
// - boot strap 00 host boot, 01/10/11 ROM boot of 8/16/32 bits.
// - lane strap high puts narrow data low in little, top in big endian.
// - lane strap low always puts narrow data on the lowest byte lane.
// - the host port select strap is latched at reset and picks pin use.
// - select low disables the host port, enables audio port and gpio.
// - select high enables the host port and disables the other two.
// - software has no way to change the latched host port choice.
// - other choices are set by software in a device config register.
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none

module reset_strap_config_capture (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // strap pins
  input wire logic byte_order_strap_in,
  input wire logic [1:0] boot_mode_strap_in,
  input wire logic narrow_lane_place_strap_in,
  input wire logic host_port_select_strap_in,
  input wire logic ref_clock_source_strap_in,
  // axi4-lite write address and data
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // latched configuration
  output logic config_valid_out,
  output logic byte_order_select_out,
  output logic [1:0] boot_mode_out,
  output logic boot_from_host_out,
  output logic narrow_lane_top_out,
  output logic host_port_enable_out,
  output logic audio_port2_enable_out,
  output logic [15:0] gpio_shared_enable_out,
  output logic ref_clock_fault_out,
  // software configuration
  output logic serial1_disable_out,
  output logic serial0_disable_out,
  output logic timer0_pin_alt_out,
  output logic timer1_pin_alt_out,
  output logic ext_mem_clk_ext_out
);

  logic [strap_cfg_pkg::STRAP_W-1:0] strap_raw;
  logic [strap_cfg_pkg::STRAP_W-1:0] strap_sync_v;

  assign strap_raw = {ref_clock_source_strap_in, host_port_select_strap_in,
                      narrow_lane_place_strap_in, boot_mode_strap_in,
                      byte_order_strap_in};

  strap_sync #(
    .WIDTH(strap_cfg_pkg::STRAP_W)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .pins_in(strap_raw),
    .sync_out(strap_sync_v)
  );

  // capture state
  logic captured, next_captured;
  logic byte_order, next_byte_order;
  logic [1:0] boot_mode, next_boot_mode;
  logic lane_strap, next_lane_strap;
  logic host_sel, next_host_sel;
  logic clk_fault, next_clk_fault;
  logic lane_top, next_lane_top;
  logic host_en, next_host_en;
  logic audio_en, next_audio_en;
  logic [15:0] gpio_en, next_gpio_en;
  logic boot_host, next_boot_host;

  always_comb
  begin
    next_captured = 1'b1;
    next_byte_order = byte_order;
    next_boot_mode = boot_mode;
    next_lane_strap = lane_strap;
    next_host_sel = host_sel;
    // the clock strap must stay right after reset too, so it is watched live
    next_clk_fault = !strap_sync_v[strap_cfg_pkg::STRAP_REF_CLK];
    // the chain settled during reset, so its output at the first edge after
    // release is the level the board held up to the release
    if (!captured)
    begin
      next_byte_order = strap_sync_v[strap_cfg_pkg::STRAP_BYTE_ORDER];
      next_boot_mode = strap_sync_v[strap_cfg_pkg::STRAP_BOOT_MSB:
                                    strap_cfg_pkg::STRAP_BOOT_LSB];
      next_lane_strap = strap_sync_v[strap_cfg_pkg::STRAP_LANE];
      next_host_sel = strap_sync_v[strap_cfg_pkg::STRAP_HOST];
    end
    next_boot_host = (next_boot_mode == strap_cfg_pkg::BOOT_HOST);
    // narrow data goes to the top lane only for big endian with lane strap high
    next_lane_top = next_lane_strap &&
                    (next_byte_order == strap_cfg_pkg::BIG_ENDIAN);
    next_host_en = next_host_sel;
    next_audio_en = !next_host_sel;
    next_gpio_en = next_host_sel ? strap_cfg_pkg::GPIO_NONE
                                 : strap_cfg_pkg::GPIO_SHARED_MASK;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      captured <= 1'b0;
      byte_order <= strap_cfg_pkg::LITTLE_ENDIAN;
      boot_mode <= strap_cfg_pkg::BOOT_ROM8;
      lane_strap <= strap_cfg_pkg::LANE_DEFAULT;
      host_sel <= strap_cfg_pkg::HOST_DEFAULT;
      clk_fault <= 1'b0;
      lane_top <= 1'b0;
      host_en <= strap_cfg_pkg::HOST_DEFAULT;
      audio_en <= !strap_cfg_pkg::HOST_DEFAULT;
      gpio_en <= strap_cfg_pkg::GPIO_NONE;
      boot_host <= 1'b0;
    end
    else
    begin
      captured <= next_captured;
      byte_order <= next_byte_order;
      boot_mode <= next_boot_mode;
      lane_strap <= next_lane_strap;
      host_sel <= next_host_sel;
      clk_fault <= next_clk_fault;
      lane_top <= next_lane_top;
      host_en <= next_host_en;
      audio_en <= next_audio_en;
      gpio_en <= next_gpio_en;
      boot_host <= next_boot_host;
    end
  end

  // register bus state
  logic aw_held, next_aw_held;
  logic w_held, next_w_held;
  logic [11:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic awready, next_awready;
  logic wready, next_wready;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic arready, next_arready;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic [4:0] cfg, next_cfg;
  logic [31:0] status_word;

  always_comb
  begin
    status_word = strap_cfg_pkg::DATA_ZERO;
    status_word[strap_cfg_pkg::STAT_BYTE_ORDER_BIT] = byte_order;
    status_word[strap_cfg_pkg::STAT_BOOT_LSB +: 2] = boot_mode;
    status_word[strap_cfg_pkg::STAT_LANE_BIT] = lane_strap;
    status_word[strap_cfg_pkg::STAT_HOST_BIT] = host_sel;
    status_word[strap_cfg_pkg::STAT_REF_CLK_BIT] = !clk_fault;
    status_word[strap_cfg_pkg::STAT_CAPTURED_BIT] = captured;
  end

  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_cfg = cfg;
    if (s_axi_awvalid_in && awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_in;
      next_w_strb = s_axi_wstrb_in;
    end
    if (bvalid && s_axi_bready_in)
    begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !bvalid)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = strap_cfg_pkg::RESP_OKAY;
      case (aw_addr)
        strap_cfg_pkg::DEVICE_CONFIG_OFFSET:
        begin
          // only the low byte holds fields; reserved bits are dropped
          if (w_strb[0])
          begin
            next_cfg = w_data[strap_cfg_pkg::CFG_W-1:0];
          end
        end
        // the strap status word is read only, so the latched host port
        // choice cannot be altered from software
        strap_cfg_pkg::STRAP_STATUS_OFFSET:
        begin
          next_bresp = strap_cfg_pkg::RESP_SLVERR;
        end
        default:
        begin
          next_bresp = strap_cfg_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_awready = !next_aw_held;
    next_wready = !next_w_held;
  end

  always_comb
  begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && s_axi_rready_in)
    begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = strap_cfg_pkg::RESP_OKAY;
      case (s_axi_araddr_in)
        strap_cfg_pkg::DEVICE_CONFIG_OFFSET:
        begin
          next_rdata = {27'h000_0000, cfg};
        end
        strap_cfg_pkg::STRAP_STATUS_OFFSET:
        begin
          next_rdata = status_word;
        end
        default:
        begin
          next_rdata = strap_cfg_pkg::DATA_ZERO;
          next_rresp = strap_cfg_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= strap_cfg_pkg::DATA_ZERO;
      w_strb <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= strap_cfg_pkg::RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= strap_cfg_pkg::DATA_ZERO;
      rresp <= strap_cfg_pkg::RESP_OKAY;
      cfg <= strap_cfg_pkg::CFG_RESET;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      cfg <= next_cfg;
    end
  end

  assign s_axi_awready_out = awready;
  assign s_axi_wready_out = wready;
  assign s_axi_bvalid_out = bvalid;
  assign s_axi_bresp_out = bresp;
  assign s_axi_arready_out = arready;
  assign s_axi_rvalid_out = rvalid;
  assign s_axi_rdata_out = rdata;
  assign s_axi_rresp_out = rresp;

  assign config_valid_out = captured;
  assign byte_order_select_out = byte_order;
  assign boot_mode_out = boot_mode;
  assign boot_from_host_out = boot_host;
  assign narrow_lane_top_out = lane_top;
  assign host_port_enable_out = host_en;
  assign audio_port2_enable_out = audio_en;
  // enable and direction stay with the gpio block's own registers
  assign gpio_shared_enable_out = gpio_en;
  assign ref_clock_fault_out = clk_fault;

  assign serial1_disable_out = cfg[strap_cfg_pkg::CFG_SERIAL1_DIS_BIT];
  assign serial0_disable_out = cfg[strap_cfg_pkg::CFG_SERIAL0_DIS_BIT];
  assign timer0_pin_alt_out = cfg[strap_cfg_pkg::CFG_TIMER0_PIN_BIT];
  assign timer1_pin_alt_out = cfg[strap_cfg_pkg::CFG_TIMER1_PIN_BIT];
  assign ext_mem_clk_ext_out = cfg[strap_cfg_pkg::CFG_EXT_MEM_CLK_BIT];

endmodule : reset_strap_config_capture

`default_nettype wire

/* hw/strap_cfg_pkg.sv */
// constants shared by the strap capture block and its synchroniser
package strap_cfg_pkg;

  // register bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [11:0] DEVICE_CONFIG_OFFSET = 12'h200;
  localparam logic [11:0] STRAP_STATUS_OFFSET = 12'h204;

  // device_config_reg fields; bits above the top field are reserved
  localparam int CFG_SERIAL1_DIS_BIT = 0;
  localparam int CFG_SERIAL0_DIS_BIT = 1;
  localparam int CFG_TIMER0_PIN_BIT = 2;
  localparam int CFG_TIMER1_PIN_BIT = 3;
  localparam int CFG_EXT_MEM_CLK_BIT = 4;
  localparam int CFG_W = 5;
  localparam logic [4:0] CFG_RESET = 5'h00;

  // strap status register fields
  localparam int STAT_BYTE_ORDER_BIT = 0;
  localparam int STAT_BOOT_LSB = 1;
  localparam int STAT_LANE_BIT = 3;
  localparam int STAT_HOST_BIT = 4;
  localparam int STAT_REF_CLK_BIT = 5;
  localparam int STAT_CAPTURED_BIT = 6;

  // strap vector layout as it enters the synchroniser
  localparam int STRAP_BYTE_ORDER = 0;
  localparam int STRAP_BOOT_LSB = 1;
  localparam int STRAP_BOOT_MSB = 2;
  localparam int STRAP_LANE = 3;
  localparam int STRAP_HOST = 4;
  localparam int STRAP_REF_CLK = 5;
  localparam int STRAP_W = 6;

  // strap encodings, and the defaults shown until the first capture after reset
  localparam logic LITTLE_ENDIAN = 1'b1;
  localparam logic BIG_ENDIAN = 1'b0;
  localparam logic [1:0] BOOT_HOST = 2'h0;
  localparam logic [1:0] BOOT_ROM8 = 2'h1;
  localparam logic [1:0] BOOT_ROM16 = 2'h2;
  localparam logic [1:0] BOOT_ROM32 = 2'h3;
  localparam logic LANE_DEFAULT = 1'b1;
  localparam logic HOST_DEFAULT = 1'b1;

  // shared general-purpose pins: 15..8, 3, 1, 0
  localparam logic [15:0] GPIO_SHARED_MASK = 16'hFF0B;
  localparam logic [15:0] GPIO_NONE = 16'h0000;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

endpackage : strap_cfg_pkg

/* hw/strap_sync.sv */
// two-flop synchroniser for the asynchronous strap pins
`timescale 1ns/100ps
`default_nettype none

module strap_sync #(
  parameter int WIDTH = 6
) (
  // clock
  input wire logic ref_clk_in,
  // pins and synchronised copy
  input wire logic [WIDTH-1:0] pins_in,
  output logic [WIDTH-1:0] sync_out
);

  // no reset here on purpose: the chain must keep tracking the pins while
  // reset is low so that the release edge sees their settled level
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic meta;
      logic stable;
      always_ff @(posedge ref_clk_in)
      begin
        meta <= pins_in[i];
        stable <= meta;
      end
      assign sync_out[i] = stable;
    end
  endgenerate

endmodule : strap_sync

`default_nettype wire

/* verif/strap_capture_sva.sv */
// assertion checker for the strap capture block
`timescale 1ns/100ps
`default_nettype none

module strap_capture_sva (
  // clock, reset and straps
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic host_port_select_strap_in,
  input wire logic ref_clock_source_strap_in,
  // bus handshakes
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rready_in,
  input wire logic s_axi_rvalid_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_bvalid_out,
  input wire logic [1:0] s_axi_bresp_out,
  // latched configuration
  input wire logic config_valid_out,
  input wire logic byte_order_select_out,
  input wire logic [1:0] boot_mode_out,
  input wire logic boot_from_host_out,
  input wire logic narrow_lane_top_out,
  input wire logic host_port_enable_out,
  input wire logic audio_port2_enable_out,
  input wire logic [15:0] gpio_shared_enable_out,
  input wire logic ref_clock_fault_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_latched_hold: assert property (config_valid_out |=> $stable({
    byte_order_select_out, boot_mode_out, host_port_enable_out}))
    else $error("latched output moved");
  a_host_capture: assert property ($rose(config_valid_out) |->
    host_port_enable_out == $past(host_port_select_strap_in, 3))
    else $error("host select not captured");
  a_boot_decode: assert property (config_valid_out |->
    boot_from_host_out == (boot_mode_out == strap_cfg_pkg::BOOT_HOST))
    else $error("host boot decode wrong");
  a_top_lane_big: assert property (narrow_lane_top_out |->
    byte_order_select_out == strap_cfg_pkg::BIG_ENDIAN)
    else $error("top lane without big endian");
  a_audio_excl: assert property (config_valid_out |->
    audio_port2_enable_out != host_port_enable_out)
    else $error("host and audio port not exclusive");
  a_gpio_share: assert property (config_valid_out |->
    gpio_shared_enable_out == (host_port_enable_out ?
    strap_cfg_pkg::GPIO_NONE : strap_cfg_pkg::GPIO_SHARED_MASK))
    else $error("shared gpio enables wrong");
  a_fault_low: assert property ((!ref_clock_source_strap_in)[*4] |->
    ref_clock_fault_out) else $error("clock strap fault missed");
  a_fault_high: assert property (ref_clock_source_strap_in[*4] |->
    !ref_clock_fault_out) else $error("false clock strap fault");
  a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped");
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=>
    s_axi_rvalid_out) else $error("read not answered");

  c_gpio_mode: cover property ($rose(config_valid_out) && !host_port_enable_out);
  c_top_lane: cover property (narrow_lane_top_out);
  c_slverr: cover property (s_axi_bvalid_out && s_axi_bresp_out[1]);
endmodule : strap_capture_sva

bind reset_strap_config_capture strap_capture_sva u_sva (.*);

`default_nettype wire

/* verif/strap_board.sv */
// board straps: pulls to the default levels unless a level is driven
`timescale 1ns/100ps
`default_nettype none

module strap_board #(
  parameter bit FLAT_PKG = 1'b0
) (
  input wire logic drive_in,
  input wire logic [5:0] level_in,
  output logic [5:0] pins_out
);
  // pulls: little endian, rom8 boot, lane high, host port, square clock
  always_comb
  begin
    pins_out = drive_in ? level_in : 6'h3B;
    if (FLAT_PKG && !pins_out[0])
    begin
      pins_out[3] = 1'b0;
    end
  end
endmodule : strap_board

`default_nettype wire

/* verif/tb_reset_strap_config_capture.sv */
// testbench for the strap capture block
`timescale 1ns/100ps
`default_nettype none

module tb_reset_strap_config_capture;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic drv = 1'b0;
  logic [5:0] lvl = 6'h3B;
  logic [5:0] pins;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, cv, bo, bh, lt, hp, ap, cf;
  logic [1:0] bresp, rresp, bm;
  logic [31:0] rdata;
  logic [15:0] gp;
  // one port drives each bit, so this is a net rather than a variable
  wire logic [4:0] sw;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;

  always #12.5 clk = ~clk;

  strap_board BOARD (.drive_in(drv), .level_in(lvl), .pins_out(pins));

  reset_strap_config_capture DUT (
    .ref_clk_in(clk), .rst_n_in(rst_n),
    .byte_order_strap_in(pins[0]), .boot_mode_strap_in(pins[2:1]),
    .narrow_lane_place_strap_in(pins[3]),
    .host_port_select_strap_in(pins[4]),
    .ref_clock_source_strap_in(pins[5]),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .config_valid_out(cv),
    .byte_order_select_out(bo), .boot_mode_out(bm),
    .boot_from_host_out(bh), .narrow_lane_top_out(lt),
    .host_port_enable_out(hp), .audio_port2_enable_out(ap),
    .gpio_shared_enable_out(gp), .ref_clock_fault_out(cf),
    .serial1_disable_out(sw[0]), .serial0_disable_out(sw[1]),
    .timer0_pin_alt_out(sw[2]), .timer1_pin_alt_out(sw[3]),
    .ext_mem_clk_ext_out(sw[4]));

  task automatic wrap_up;
    if (fails == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, er);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, ed);
    chk(rresp, er);
  endtask : rd

  // expected latched outputs for straps: byte order, boot, lane, host
  function automatic logic [31:0] exp_cfg(input logic [4:0] s);
    return {1'b1, s[0], s[2:1], s[2:1] == 2'h0, !s[0] && s[3], s[4],
            !s[4], s[4] ? strap_cfg_pkg::GPIO_NONE
            : strap_cfg_pkg::GPIO_SHARED_MASK, 1'b0};
  endfunction : exp_cfg

  task automatic chk_cfg(input logic [4:0] s);
    chk({cv, bo, bm, bh, lt, hp, ap, gp, cf}, exp_cfg(s));
    rd(strap_cfg_pkg::STRAP_STATUS_OFFSET, {2'b11, s}, 2'h0);
  endtask : chk_cfg

  task automatic restrap(input logic [4:0] s);
    @(posedge clk);
    rst_n <= 1'b0;
    drv <= 1'b1;
    lvl <= {1'b1, s};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : restrap

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      wrap_up();
    end
  end

  // 5'h1c is big endian with the lane strap high: the only top lane case
  logic [4:0] tbl [4] = '{5'h19, 5'h02, 5'h1C, 5'h07};

  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk_cfg(5'h1B);
    foreach (tbl[i])
    begin
      restrap(tbl[i]);
      chk_cfg(tbl[i]);
      lvl <= {1'b1, ~tbl[i]};
      wr(strap_cfg_pkg::STRAP_STATUS_OFFSET, 32'hFFFF_FFFF, 2'h2);
      chk_cfg(tbl[i]);
    end
    wr(strap_cfg_pkg::DEVICE_CONFIG_OFFSET, 32'hFFFF_FFFF, 2'h0);
    rd(strap_cfg_pkg::DEVICE_CONFIG_OFFSET, 32'h0000_001F, 2'h0);
    chk(sw, 5'h1F);
    wr(strap_cfg_pkg::DEVICE_CONFIG_OFFSET, 32'h0000_0005, 2'h0);
    chk(sw, 5'h05);
    // a write without the low byte lane must leave the fields alone
    wstrb <= 4'h0;
    wr(strap_cfg_pkg::DEVICE_CONFIG_OFFSET, 32'h0000_001A, 2'h0);
    wstrb <= 4'hF;
    chk(sw, 5'h05);
    rd(12'h300, 32'h0000_0000, 2'h2);
    wr(12'h300, 32'h0000_001A, 2'h2);
    rd(strap_cfg_pkg::DEVICE_CONFIG_OFFSET, 32'h0000_0005, 2'h0);
    lvl <= 6'h1B;
    repeat (6) @(posedge clk);
    chk(cf, 1'b1);
    lvl <= 6'h3B;
    repeat (6) @(posedge clk);
    chk(cf, 1'b0);
    wrap_up();
  end
endmodule : tb_reset_strap_config_capture

`default_nettype wire
